// ---- hdl/wake_hs_pkg.sv ----
package wake_hs_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [3:0] ctrl_offset = 4'h0;
	localparam logic [3:0] status_offset = 4'h4;
	localparam logic [3:0] txdata_offset = 4'h8;
	localparam logic [3:0] rxdata_offset = 4'hc;
	localparam int lead_lsb = 0;
	localparam int lead_w = 4;
	localparam int req_en_bit = 4;
	localparam int auto_mode_bit = 5;
	localparam int req_pin_sel_bit = 6;
	localparam int cts_fc_bit = 7;
	localparam int rts_fc_bit = 8;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int clk_mhz = 100;
	localparam int lead_unit_us = 625;
	localparam int lead_unit_cycles = lead_unit_us * clk_mhz;
	localparam int wake_min_ms = 3;
	localparam int wake_min_cycles = wake_min_ms * 1000 * clk_mhz;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		tx_idle,
		tx_lead,
		tx_send
	} tx_state_t;

	typedef struct packed
	{
		logic [lead_w-1:0] lead;
		logic req_en;
		logic auto_mode;
		logic req_pin_sel;
		logic cts_fc;
		logic rts_fc;
	} ctrl_t;

	typedef struct packed
	{
		logic [7:0] data;
		logic valid;
	} byte_t;

	function automatic logic [31:0] ctrl_pack(input ctrl_t c);
		logic [31:0] w;
		w = '0;
		w[lead_lsb +: lead_w] = c.lead;
		w[req_en_bit] = c.req_en;
		w[auto_mode_bit] = c.auto_mode;
		w[req_pin_sel_bit] = c.req_pin_sel;
		w[cts_fc_bit] = c.cts_fc;
		w[rts_fc_bit] = c.rts_fc;
		return w;
	endfunction : ctrl_pack

endpackage : wake_hs_pkg

// ---- hdl/uart_wake_handshake.sv ----
module uart_wake_handshake
	import wake_hs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic host_request_cts_pin,
	input wire logic host_request_rts_pin,
	input wire logic shutdown_req,
	output logic host_wake_indicator,
	output logic [7:0] uart_tx_data,
	output logic uart_tx_valid,
	input wire logic uart_tx_ready,
	input wire logic [7:0] uart_rx_data,
	input wire logic uart_rx_valid,
	output logic reduced_current,
	output logic in_shutdown
);
	import wake_hs_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ctrl_t ctrl_r;
	tx_state_t tx_state_r;
	tx_state_t tx_state_nxt;
	byte_t tx_hold_r;
	byte_t rx_hold_r;
	logic rx_overrun_r;
	logic [lead_w+17:0] lead_cnt_r;
	logic [21:0] wake_cnt_r;
	logic awake_r;
	logic shutdown_r;
	logic [2:0] req_sync_r;
	logic req_low_r;
	logic aw_got_r;
	logic w_got_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	wire logic rd_rx;

	// ----------------------------------------------------------------
	// Request pin selection and three-stage synchroniser
	// ----------------------------------------------------------------
	wire logic req_pin_raw;
	wire logic pin_conflict;
	assign req_pin_raw = ctrl_r.req_pin_sel ? host_request_rts_pin : host_request_cts_pin;
	// A pin still used for its flow control role cannot carry the request.
	assign pin_conflict = ctrl_r.req_pin_sel ? ctrl_r.rts_fc : ctrl_r.cts_fc;

	// Input passes three flops; a level counts once the last two agree.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			req_sync_r <= 3'h7;
			req_low_r <= 1'b0;
		end
		else
		begin
			req_sync_r <= {req_sync_r[1:0], req_pin_raw};
			if (req_sync_r[1] == req_sync_r[2])
				req_low_r <= ~req_sync_r[2];
		end
	end

	wire logic req_active;
	wire logic sleep_allowed;
	assign req_active = ctrl_r.req_en & ~pin_conflict & req_low_r;
	assign sleep_allowed = ctrl_r.req_en & ~pin_conflict;

	// ----------------------------------------------------------------
	// Wake and sleep tracking
	// ----------------------------------------------------------------
	// Controller counts as awake once the request has been low for the wake time.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_cnt_r <= '0;
			awake_r <= 1'b0;
			shutdown_r <= 1'b0;
		end
		else
		begin
			if (shutdown_req && !req_active)
				shutdown_r <= 1'b1;
			else if (req_active)
				shutdown_r <= 1'b0;
			if (!req_active)
			begin
				wake_cnt_r <= '0;
				awake_r <= 1'b0;
			end
			else if (wake_cnt_r < 22'(wake_min_cycles - 1))
				wake_cnt_r <= wake_cnt_r + 22'h1;
			else
				awake_r <= 1'b1;
		end
	end

	wire logic asleep;
	assign asleep = sleep_allowed & ~awake_r;
	assign reduced_current = asleep;
	assign in_shutdown = shutdown_r;

	// ----------------------------------------------------------------
	// Transmit path with indicator and lead delay
	// ----------------------------------------------------------------
	wire logic [lead_w+17:0] lead_cycles;
	wire logic ind_en;
	wire logic tx_go;
	assign lead_cycles = (lead_w + 18)'(ctrl_r.lead * lead_unit_cycles);
	assign ind_en = (ctrl_r.lead != '0);
	// Pending data stays held while the controller sleeps.
	assign tx_go = ~asleep & ~shutdown_r;

	always_comb
	begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			tx_idle:
				if (tx_hold_r.valid && tx_go)
					tx_state_nxt = ind_en ? tx_lead : tx_send;
			tx_lead:
				if (lead_cnt_r >= lead_cycles - (lead_w + 18)'(1))
					tx_state_nxt = tx_send;
			tx_send:
				if (!tx_hold_r.valid || (uart_tx_valid && uart_tx_ready))
					tx_state_nxt = tx_idle;
			default:
				tx_state_nxt = tx_idle;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state_r <= tx_idle;
			lead_cnt_r <= '0;
		end
		else
		begin
			tx_state_r <= tx_state_nxt;
			lead_cnt_r <= (tx_state_r == tx_lead) ? lead_cnt_r + (lead_w + 18)'(1) : '0;
		end
	end

	// Indicator is held over the lead delay and until the single held byte is taken.
	assign host_wake_indicator = ind_en & (tx_state_r != tx_idle);
	assign uart_tx_data = tx_hold_r.data;
	assign uart_tx_valid = (tx_state_r == tx_send) & tx_hold_r.valid & tx_go;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	wire logic wr_fire;
	wire logic tx_wr;
	assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
	assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign tx_wr = wr_fire & (awaddr_r == txdata_offset) & ~tx_hold_r.valid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
			ctrl_r <= ctrl_t'(ctrl_reset[8:0]);
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r == ctrl_offset || tx_wr) ? resp_okay : resp_slverr;
				if (awaddr_r == ctrl_offset)
				begin
					ctrl_r.lead <= wdata_r[lead_lsb +: lead_w];
					ctrl_r.req_en <= wdata_r[req_en_bit];
					ctrl_r.auto_mode <= wdata_r[auto_mode_bit];
					ctrl_r.req_pin_sel <= wdata_r[req_pin_sel_bit];
					ctrl_r.cts_fc <= wdata_r[cts_fc_bit];
					ctrl_r.rts_fc <= wdata_r[rts_fc_bit];
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Transmit holding byte and receive holding byte.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_hold_r <= '0;
			rx_hold_r <= '0;
			rx_overrun_r <= 1'b0;
		end
		else
		begin
			if (tx_wr)
				tx_hold_r <= '{data: wdata_r[7:0], valid: 1'b1};
			else if (uart_tx_valid && uart_tx_ready)
				tx_hold_r.valid <= 1'b0;
			// Received bytes are dropped while asleep.
			if (uart_rx_valid && !asleep && !shutdown_r)
			begin
				rx_overrun_r <= rx_overrun_r | rx_hold_r.valid;
				rx_hold_r <= '{data: uart_rx_data, valid: 1'b1};
			end
			else if (rd_rx)
				rx_hold_r.valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	wire logic [31:0] status_word;
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_rx = s_axi_arvalid & s_axi_arready & (s_axi_araddr == rxdata_offset);
	assign status_word = {22'h0, rx_overrun_r, rx_hold_r.valid, pin_conflict, shutdown_r,
		asleep, awake_r, host_wake_indicator, tx_hold_r.valid, 2'(tx_state_r)};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= resp_okay;
			case (s_axi_araddr)
				ctrl_offset: s_axi_rdata <= ctrl_pack(ctrl_r);
				status_offset: s_axi_rdata <= status_word;
				txdata_offset: s_axi_rdata <= {24'h0, tx_hold_r.data};
				rxdata_offset: s_axi_rdata <= {23'h0, rx_hold_r.valid, rx_hold_r.data};
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= resp_slverr;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule : uart_wake_handshake

// ---- tb/wake_hs_assertions.sv ----
// ----
// Port checks
// ----
module wake_hs_assertions
	import wake_hs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic host_wake_indicator,
	input wire logic [7:0] uart_tx_data,
	input wire logic uart_tx_valid,
	input wire logic uart_tx_ready,
	input wire logic reduced_current
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [19:0] ind_cnt_r;
	// Counts the cycles for which the indicator has stood high.
	always_ff @(posedge aclk)
		if (!aresetn || !host_wake_indicator)
			ind_cnt_r <= '0;
		else
			ind_cnt_r <= ind_cnt_r + 20'h1;
	// A byte handed to the UART, and the first offer after the lead.
	sequence byte_taken;
		uart_tx_valid && uart_tx_ready;
	endsequence
	sequence lead_over;
		$rose(uart_tx_valid) && host_wake_indicator;
	endsequence
	lead_wait_a: assert property (lead_over |-> ind_cnt_r >= lead_unit_cycles - 1)
		else $error("Byte offered before the lead delay.");
	ind_hold_a: assert property (host_wake_indicator && !uart_tx_valid && !reduced_current |=> host_wake_indicator)
		else $error("Indicator fell before the byte went.");
	ind_drop_a: assert property (byte_taken ##0 host_wake_indicator |=> !host_wake_indicator)
		else $error("Indicator stayed after the last byte.");
	no_tx_sleep_a: assert property (reduced_current && $past(reduced_current) |-> !uart_tx_valid)
		else $error("Byte offered while asleep.");
	tx_hold_a: assert property (uart_tx_valid && !uart_tx_ready && !reduced_current |=>
		uart_tx_valid && $stable(uart_tx_data))
		else $error("Byte offer changed before it was taken.");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write response dropped early.");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("Write address taken during a response.");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid[*1] ##0 !s_axi_arready)
		else $error("Read answer late.");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("Read data dropped early.");
endmodule : wake_hs_assertions

bind uart_wake_handshake wake_hs_assertions wake_hs_assertions_inst (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.host_wake_indicator, .uart_tx_data, .uart_tx_valid, .uart_tx_ready, .reduced_current);

// ---- tb/host_model.sv ----
module host_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wake_req,
	input wire logic stall,
	input wire logic [7:0] uart_tx_data,
	input wire logic uart_tx_valid,
	output logic uart_tx_ready,
	output logic host_request_pin,
	output logic [7:0] last_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// The request is active low and follows wake_req directly.
	assign host_request_pin = !wake_req;
	assign uart_tx_ready = !stall;
	// Keeps the last byte received from the block.
	always_ff @(posedge aclk)
		if (!aresetn)
			last_byte <= 8'h00;
		else if (uart_tx_valid && uart_tx_ready)
			last_byte <= uart_tx_data;
endmodule : host_model

// ---- tb/uart_wake_handshake_tb.sv ----
module uart_wake_handshake_tb;
	import wake_hs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, uart_rx_valid = 0, wake_req = 0, stall = 0, shutdown_req = 0;
	logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [7:0] uart_rx_data = '0, uart_tx_data, last_byte;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_wake_indicator;
	logic uart_tx_valid, uart_tx_ready, reduced_current, in_shutdown, host_request_pin, ind_seen;
	wire host_request_cts_pin = host_request_pin;
	wire host_request_rts_pin = host_request_pin;
	int n_fail = 0;
	int n_tests = 0;
	uart_wake_handshake uart_wake_handshake_inst (.*);
	host_model host_model_inst (.*);
	initial
		forever #5 aclk = ~aclk;
	// Remembers any indicator activity.
	always @(posedge aclk)
		if (host_wake_indicator)
			ind_seen = 1'b1;
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
	endtask : wr
	task automatic rd_reg(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
	endtask : rd_reg
	task automatic rx_push(input logic [7:0] b);
		uart_rx_data <= b;
		uart_rx_valid <= 1'b1;
		@(posedge aclk);
		uart_rx_valid <= 1'b0;
	endtask : rx_push
	task automatic t_basic();
		rd_reg(ctrl_offset);
		chk("ctrl", rd, ctrl_reset);
		chk("asleep", reduced_current, 1'b0);
		wr(status_offset, 32'h0);
		chk("status wr", rs, resp_slverr);
		rx_push(8'h3c);
		rd_reg(rxdata_offset);
		chk("rx", rd[8:0], 9'h13c);
	endtask : t_basic
	task automatic t_no_lead();
		for (int m = 0; m < 2; m++)
		begin
			wr(ctrl_offset, 32'(m) << auto_mode_bit);
			ind_seen = 1'b0;
			stall <= 1'b1;
			wr(txdata_offset, 32'h5a + m);
			repeat (5) @(posedge aclk);
			chk("tx valid", uart_tx_valid, 1'b1);
			stall <= 1'b0;
			repeat (3) @(posedge aclk);
			chk("byte", last_byte, 32'h5a + m);
			chk("indicator", ind_seen, 1'b0);
		end
	endtask : t_no_lead
	task automatic t_lead();
		int n;
		wr(ctrl_offset, 32'h21);
		stall <= 1'b1;
		wr(txdata_offset, 32'hc3);
		wr(txdata_offset, 32'h11);
		chk("busy wr", rs, resp_slverr);
		chk("indicator up", host_wake_indicator, 1'b1);
		for (n = 0; n < 70000 && !uart_tx_valid; n++)
			@(posedge aclk);
		chk("lead", 32'(n >= lead_unit_cycles - 20 && n <= lead_unit_cycles), 1);
		repeat (10) @(posedge aclk);
		chk("indicator held", host_wake_indicator, 1'b1);
		stall <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("indicator off", host_wake_indicator, 1'b0);
		chk("byte", last_byte, 8'hc3);
	endtask : t_lead
	task automatic t_sleep();
		wr(ctrl_offset, 32'h1 << req_en_bit);
		repeat (5) @(posedge aclk);
		chk("asleep", reduced_current, 1'b1);
		rx_push(8'h42);
		wr(txdata_offset, 32'h77);
		repeat (20) @(posedge aclk);
		chk("tx asleep", uart_tx_valid, 1'b0);
		rd_reg(rxdata_offset);
		chk("rx asleep", rd[8], 1'b0);
		rd_reg(status_offset);
		chk("pending", rd[2], 1'b1);
		shutdown_req <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("shutdown", in_shutdown, 1'b1);
		shutdown_req <= 1'b0;
		wake_req <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("shutdown woken", in_shutdown, 1'b0);
		chk("still waking", reduced_current, 1'b1);
		chk("tx waking", uart_tx_valid, 1'b0);
		wake_req <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("asleep again", reduced_current, 1'b1);
		wr(ctrl_offset, (32'h1 << req_en_bit) | (32'h1 << cts_fc_bit));
		repeat (2) @(posedge aclk);
		chk("pin conflict", reduced_current, 1'b0);
		wr(ctrl_offset, 32'h0);
		repeat (5) @(posedge aclk);
		chk("awake", reduced_current, 1'b0);
		chk("held byte", last_byte, 8'h77);
	endtask : t_sleep
	task automatic results();
		$display("tests %0d errors %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// Main sequence after six cycles of reset.
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_basic();
		t_no_lead();
		t_lead();
		t_sleep();
		results();
	end
	// Cuts a hang short well past the lead delay.
	initial
	begin
		repeat (90000) @(posedge aclk);
		n_fail++;
		results();
	end
endmodule : uart_wake_handshake_tb
